// [core/sysclk_pkg.sv]
// Constants shared by the system clock and power-down control block.
// Assumes a single clock domain; all fields sit in 24-bit or 8-bit registers.
package sysclk_pkg;
  // Register addresses seen on the serial port
  localparam logic [4:0] addr_chan_select = 5'h00;
  localparam logic [4:0] addr_global_fr1 = 5'h01;
  localparam logic [4:0] addr_chan_function = 5'h03;
  // Register widths in bits
  localparam logic [4:0] len_chan_select = 5'h08;
  localparam logic [4:0] len_wide_reg = 5'h18;
  // Channel select fields
  localparam int chan0_enable_bit = 6;
  localparam int chan1_enable_bit = 7;
  // Global register fields
  localparam int vco_gain_bit = 23;
  localparam int mult_msb = 22;
  localparam int mult_lsb = 18;
  localparam int pump_msb = 17;
  localparam int pump_lsb = 16;
  localparam int clkin_pd_bit = 7;
  localparam int full_pd_sel_bit = 6;
  // Channel register fields
  localparam int dac_scale_msb = 9;
  localparam int dac_scale_lsb = 8;
  localparam int dac_pd_bit = 7;
  localparam int digital_pd_bit = 6;
  // Multiplier range
  localparam logic [4:0] mult_min = 5'h04;
  localparam logic [4:0] mult_max = 5'h14;
  localparam logic [4:0] mult_bypass = 5'h01;
  // DAC scale codes
  localparam logic [1:0] scale_full = 2'h3;
  localparam logic [1:0] scale_half = 2'h1;
  localparam logic [1:0] scale_quarter = 2'h2;
  localparam logic [1:0] scale_eighth = 2'h0;
  // Charge pump code for the default current
  localparam logic [1:0] pump_default = 2'h0;
  // Reset values
  localparam logic [7:0] chan_select_reset = 8'hc0;
  localparam logic [23:0] global_fr1_reset = 24'h000000;
  localparam logic [23:0] chan_function_reset = 24'h000300;
  // Serial instruction fields
  localparam int instr_read_bit = 7;
  localparam logic [4:0] instr_last_bit = 5'h07;
  typedef enum logic [1:0] {st_instr, st_data, st_skip} spi_state_type;
endpackage

// [core/sync2.sv]
// Two flip-flop synchroniser for asynchronous pins.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
  parameter int width = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [width-1:0] d,
  output logic [width-1:0] q
);
  logic [width-1:0] meta_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [core/chan_power_scale.sv]
// Per-channel DAC scale decode and power-down resolution.
// Assumes the external power-down level is already synchronised.
`timescale 1ns/1ns
`default_nettype none
module chan_power_scale (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [23:0] chan_function,
  input wire logic ext_pd,
  input wire logic full_pd,
  output logic [1:0] dac_atten_q,
  output logic dac_pd_q,
  output logic digital_pd_q
);
  logic [1:0] scale_code;

  assign scale_code = chan_function[sysclk_pkg::dac_scale_msb:sysclk_pkg::dac_scale_lsb];

  // Attenuation as a right shift of the full-scale current
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_atten_q <= 2'h0;
    end else if (ce) begin
      case (scale_code)
        sysclk_pkg::scale_full: dac_atten_q <= 2'h0;
        sysclk_pkg::scale_half: dac_atten_q <= 2'h1;
        sysclk_pkg::scale_quarter: dac_atten_q <= 2'h2;
        default: dac_atten_q <= 2'h3;
      endcase
    end
  end

  // Pin wins over the channel bits; one means powered down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dac_pd_q <= 1'b0;
      digital_pd_q <= 1'b0;
    end else if (ce) begin
      if (ext_pd) begin
        dac_pd_q <= full_pd;
        digital_pd_q <= 1'b1;
      end else begin
        dac_pd_q <= chan_function[sysclk_pkg::dac_pd_bit];
        digital_pd_q <= chan_function[sysclk_pkg::digital_pd_bit];
      end
    end
  end
endmodule
`default_nettype wire

// [core/sysclk_and_powerdown_ctrl.sv]
// System clock source selection, PLL control, DAC scaling and power-down.
// Assumes a slow serial port (sclk well below clk/4) and async pins.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Multiplier held in global bits 22:18
// - Factor 4..20 enables PLL multiplication
// - Other factors bypass PLL, factor one
// - PLL range 100-500 MHz; VCO gain bit
// - VCO gain resets to low range
// - Charge pump resets to 75 uA
// - Mode pin picks buffer or crystal oscillator
// - Channel bits 9:8 scale DAC current
// - Channel bits 7:6 are software power-downs
// - Pin high ignores software power-down bits
// - Pin high, bit 6 clear: fast recovery
// - Pin high, bit 6 set: full power-down
// - Bypassed multiplier keeps PLL shut down
// - Pin low lets software bits govern
// - Power-down controls: one means low power
// - Channel register lives at address 0x03
module sysclk_and_powerdown_ctrl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo_q,
  output logic sdo_oe_n,
  input wire logic clk_mode_sel,
  input wire logic external_powerdown_pin,
  output logic pll_enable_q,
  output logic pll_powered_q,
  output logic [4:0] clk_factor_q,
  output logic vco_gain_high_q,
  output logic [1:0] charge_pump_q,
  output logic xtal_osc_enable_q,
  output logic ref_buffer_enable_q,
  output logic clk_input_pd_q,
  output logic fast_recovery_pd_q,
  output logic full_pd_q,
  output logic [1:0] dac0_atten_q,
  output logic dac0_pd_q,
  output logic digital0_pd_q,
  output logic [1:0] dac1_atten_q,
  output logic dac1_pd_q,
  output logic digital1_pd_q
);
  logic [4:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic mode_s;
  logic ext_pd_s;
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  sysclk_pkg::spi_state_type state_q;
  logic [4:0] bit_cnt_q;
  logic [4:0] len_q;
  logic [4:0] addr_q;
  logic read_q;
  logic [23:0] in_sr_q;
  logic [23:0] out_sr_q;
  logic [23:0] in_next;
  logic [7:0] chan_select_q;
  logic [23:0] global_fr1_q;
  logic [23:0] chan_function_q [2];
  logic [4:0] mult;
  logic mult_in_range;
  logic full_sel;

  sync2 #(.width(5)) pin_sync (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .d({sclk, cs_n, sdi, clk_mode_sel, external_powerdown_pin}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[4];
  assign cs_n_s = pins_s[3];
  assign sdi_s = pins_s[2];
  assign mode_s = pins_s[1];
  assign ext_pd_s = pins_s[0];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign in_next = {in_sr_q[22:0], sdi_s};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_q <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= sclk_s;
    end
  end

  // Serial frame sequencing: instruction byte, then register data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= sysclk_pkg::st_instr;
      bit_cnt_q <= 5'h00;
      len_q <= sysclk_pkg::len_chan_select;
      addr_q <= 5'h00;
      read_q <= 1'b0;
      in_sr_q <= 24'h000000;
    end else if (ce) begin
      if (cs_n_s) begin
        state_q <= sysclk_pkg::st_instr;
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        in_sr_q <= in_next;
        bit_cnt_q <= bit_cnt_q + 5'h01;
        case (state_q)
          sysclk_pkg::st_instr: begin
            if (bit_cnt_q == sysclk_pkg::instr_last_bit) begin
              bit_cnt_q <= 5'h00;
              addr_q <= in_next[4:0];
              read_q <= in_next[sysclk_pkg::instr_read_bit];
              if (in_next[4:0] == sysclk_pkg::addr_chan_select) begin
                len_q <= sysclk_pkg::len_chan_select;
                state_q <= sysclk_pkg::st_data;
              end else if (in_next[4:0] == sysclk_pkg::addr_global_fr1) begin
                len_q <= sysclk_pkg::len_wide_reg;
                state_q <= sysclk_pkg::st_data;
              end else if (in_next[4:0] == sysclk_pkg::addr_chan_function) begin
                len_q <= sysclk_pkg::len_wide_reg;
                state_q <= sysclk_pkg::st_data;
              end else begin
                state_q <= sysclk_pkg::st_skip;
              end
            end
          end
          sysclk_pkg::st_data: begin
            if (bit_cnt_q == len_q - 5'h01) begin
              state_q <= sysclk_pkg::st_skip;
            end
          end
          default: begin
            bit_cnt_q <= 5'h00;
          end
        endcase
      end
    end
  end

  logic write_done;
  assign write_done = !cs_n_s && sclk_rise && state_q == sysclk_pkg::st_data
    && !read_q && bit_cnt_q == len_q - 5'h01;

  // Register writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      chan_select_q <= sysclk_pkg::chan_select_reset;
      global_fr1_q <= sysclk_pkg::global_fr1_reset;
      chan_function_q[0] <= sysclk_pkg::chan_function_reset;
      chan_function_q[1] <= sysclk_pkg::chan_function_reset;
    end else if (ce && write_done) begin
      if (addr_q == sysclk_pkg::addr_chan_select) begin
        chan_select_q <= in_next[7:0];
      end else if (addr_q == sysclk_pkg::addr_global_fr1) begin
        global_fr1_q <= in_next;
      end else if (addr_q == sysclk_pkg::addr_chan_function) begin
        if (chan_select_q[sysclk_pkg::chan0_enable_bit]) begin
          chan_function_q[0] <= in_next;
        end
        if (chan_select_q[sysclk_pkg::chan1_enable_bit]) begin
          chan_function_q[1] <= in_next;
        end
      end
    end
  end

  // Output enable: on from a read instruction until deselect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sdo_oe_n <= 1'b1;
    end else if (ce) begin
      if (cs_n_s) begin
        sdo_oe_n <= 1'b1;
      end else if (sclk_rise && state_q == sysclk_pkg::st_instr
          && bit_cnt_q == sysclk_pkg::instr_last_bit) begin
        sdo_oe_n <= ~in_next[sysclk_pkg::instr_read_bit];
      end
    end
  end

  // Read data: loaded after the instruction, shifted on falling sclk
  // Cleared on load so a read of an unmapped address shows zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_sr_q <= 24'h000000;
      sdo_q <= 1'b0;
    end else if (ce) begin
      if (!cs_n_s && sclk_rise && state_q == sysclk_pkg::st_instr
          && bit_cnt_q == sysclk_pkg::instr_last_bit) begin
        sdo_q <= 1'b0;
        if (in_next[4:0] == sysclk_pkg::addr_chan_select) begin
          out_sr_q <= {chan_select_q, 16'h0000};
        end else if (in_next[4:0] == sysclk_pkg::addr_global_fr1) begin
          out_sr_q <= global_fr1_q;
        end else if (in_next[4:0] == sysclk_pkg::addr_chan_function) begin
          out_sr_q <= chan_select_q[sysclk_pkg::chan0_enable_bit] ? chan_function_q[0]
            : chan_function_q[1];
        end else begin
          out_sr_q <= 24'h000000;
        end
      end else if (!cs_n_s && sclk_fall && state_q == sysclk_pkg::st_data && read_q) begin
        sdo_q <= out_sr_q[23];
        out_sr_q <= {out_sr_q[22:0], 1'b0};
      end
    end
  end

  // Clock source and PLL decode
  assign mult = global_fr1_q[sysclk_pkg::mult_msb:sysclk_pkg::mult_lsb];
  assign mult_in_range = mult >= sysclk_pkg::mult_min && mult <= sysclk_pkg::mult_max;
  assign full_sel = global_fr1_q[sysclk_pkg::full_pd_sel_bit];

  // Multiplier factor; out-of-range values give a unit factor
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_enable_q <= 1'b0;
      clk_factor_q <= sysclk_pkg::mult_bypass;
    end else if (ce) begin
      pll_enable_q <= mult_in_range;
      clk_factor_q <= mult_in_range ? mult : sysclk_pkg::mult_bypass;
    end
  end

  // PLL off when bypassed or in full power-down
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_powered_q <= 1'b0;
    end else if (ce) begin
      pll_powered_q <= mult_in_range && !(ext_pd_s && full_sel);
    end
  end

  // Loop settings passed straight through; range match is software's duty
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      vco_gain_high_q <= 1'b0;
      charge_pump_q <= sysclk_pkg::pump_default;
    end else if (ce) begin
      vco_gain_high_q <= global_fr1_q[sysclk_pkg::vco_gain_bit];
      charge_pump_q <= global_fr1_q[sysclk_pkg::pump_msb:sysclk_pkg::pump_lsb];
    end
  end

  // Reference input path: buffer or crystal oscillator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xtal_osc_enable_q <= 1'b0;
      ref_buffer_enable_q <= 1'b1;
    end else if (ce) begin
      xtal_osc_enable_q <= mode_s && !(ext_pd_s && full_sel);
      ref_buffer_enable_q <= !mode_s && !(ext_pd_s && full_sel);
    end
  end

  // Global power-down; the pin overrides the software bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clk_input_pd_q <= 1'b0;
      fast_recovery_pd_q <= 1'b0;
      full_pd_q <= 1'b0;
    end else if (ce) begin
      fast_recovery_pd_q <= ext_pd_s && !full_sel;
      full_pd_q <= ext_pd_s && full_sel;
      if (ext_pd_s) begin
        clk_input_pd_q <= full_sel;
      end else begin
        clk_input_pd_q <= global_fr1_q[sysclk_pkg::clkin_pd_bit];
      end
    end
  end

  chan_power_scale chan0 (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .chan_function(chan_function_q[0]),
    .ext_pd(ext_pd_s),
    .full_pd(full_sel),
    .dac_atten_q(dac0_atten_q),
    .dac_pd_q(dac0_pd_q),
    .digital_pd_q(digital0_pd_q)
  );

  chan_power_scale chan1 (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .chan_function(chan_function_q[1]),
    .ext_pd(ext_pd_s),
    .full_pd(full_sel),
    .dac_atten_q(dac1_atten_q),
    .dac_pd_q(dac1_pd_q),
    .digital_pd_q(digital1_pd_q)
  );
endmodule
`default_nettype wire

// [verification/sysclk_monitor.sv]
// Checker for clock source, PLL and power-down outputs.
// Bound to the top block; sees its ports only, ce held high.
`timescale 1ns/1ns
`default_nettype none
module sysclk_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_mode_sel,
  input wire logic external_powerdown_pin,
  input wire logic pll_enable_q,
  input wire logic pll_powered_q,
  input wire logic [4:0] clk_factor_q,
  input wire logic vco_gain_high_q,
  input wire logic [1:0] charge_pump_q,
  input wire logic xtal_osc_enable_q,
  input wire logic ref_buffer_enable_q,
  input wire logic clk_input_pd_q,
  input wire logic fast_recovery_pd_q,
  input wire logic full_pd_q,
  input wire logic dac0_pd_q,
  input wire logic digital0_pd_q,
  input wire logic dac1_pd_q,
  input wire logic digital1_pd_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_PLL_ON: assert property (pll_enable_q |-> clk_factor_q >= 5'h04 && clk_factor_q <= 5'h14 && pll_powered_q != full_pd_q)
    else $error("PLL on with wrong factor or supply");
  AST_BYPASS: assert property (!pll_enable_q |-> clk_factor_q == 5'h01 && !pll_powered_q)
    else $error("Bypass without unit factor or PLL off");
  AST_RESET_VAL: assert property ($rose(rstn) |-> !vco_gain_high_q && charge_pump_q == 2'h0)
    else $error("Gain or pump not at default");
  AST_FAST_PD: assert property (fast_recovery_pd_q |-> digital0_pd_q && digital1_pd_q && !dac0_pd_q && !dac1_pd_q && !clk_input_pd_q)
    else $error("Fast recovery state wrong");
  AST_FULL_PD: assert property (full_pd_q |-> !pll_powered_q && !xtal_osc_enable_q && !ref_buffer_enable_q && dac0_pd_q && dac1_pd_q && clk_input_pd_q)
    else $error("Full power-down leaves something on");
  AST_PIN_HIGH: assert property (external_powerdown_pin [*4] |-> fast_recovery_pd_q != full_pd_q)
    else $error("Pin high without one power-down mode");
  AST_PIN_LOW: assert property (!external_powerdown_pin [*4] |-> !fast_recovery_pd_q && !full_pd_q)
    else $error("Pin low but external power-down active");
  AST_CLK_MODE: assert property ($stable(clk_mode_sel) [*4] |-> full_pd_q || (xtal_osc_enable_q == clk_mode_sel && ref_buffer_enable_q != clk_mode_sel))
    else $error("Clock input mode does not follow pin");
endmodule
`default_nettype wire

// [verification/ext_pins_model.sv]
// Board-side driver of the crystal mode pin and power-down pin.
// Assumes requests from the bench; pins move just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module ext_pins_model (
  input wire logic clk,
  input wire logic xtal_req,
  input wire logic pd_req,
  output logic clk_mode_sel,
  output logic external_powerdown_pin
);
  initial clk_mode_sel = 1'b0;
  initial external_powerdown_pin = 1'b0;
  always @(posedge clk) begin
    clk_mode_sel <= xtal_req;
    external_powerdown_pin <= pd_req;
  end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench: serial register access and pin scenarios.
// Assumes the block's serial port timing and 3-clock pin latency.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  logic xtal_req = 1'b0;
  logic pd_req = 1'b0;
  logic sdo_q, sdo_oe_n, clk_mode_sel, external_powerdown_pin, pll_enable_q, pll_powered_q;
  logic vco_gain_high_q, xtal_osc_enable_q, ref_buffer_enable_q, clk_input_pd_q;
  logic fast_recovery_pd_q, full_pd_q, dac0_pd_q, digital0_pd_q, dac1_pd_q, digital1_pd_q;
  logic [4:0] clk_factor_q;
  logic [1:0] charge_pump_q, dac0_atten_q, dac1_atten_q;
  logic [23:0] rd;
  logic oe_seen;
  // Lock wait, scaled down for simulation
  localparam int lock_wait = 16;
  logic [4:0] mults [7] = '{5'h00, 5'h03, 5'h04, 5'h0c, 5'h14, 5'h15, 5'h1f};
  logic [1:0] atten_exp [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
  logic inr;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  sysclk_and_powerdown_ctrl i_dut (.clk, .rstn, .ce, .sclk, .cs_n, .sdi, .sdo_q, .sdo_oe_n,
    .clk_mode_sel, .external_powerdown_pin, .pll_enable_q, .pll_powered_q, .clk_factor_q,
    .vco_gain_high_q, .charge_pump_q, .xtal_osc_enable_q, .ref_buffer_enable_q,
    .clk_input_pd_q, .fast_recovery_pd_q, .full_pd_q, .dac0_atten_q, .dac0_pd_q,
    .digital0_pd_q, .dac1_atten_q, .dac1_pd_q, .digital1_pd_q);
  ext_pins_model i_pins (.clk, .xtal_req, .pd_req, .clk_mode_sel, .external_powerdown_pin);
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Serial frame: instruction then n data bits, MSB first
  task automatic spi(input logic [7:0] ins, input logic [23:0] dat, input int n);
    logic [31:0] w;
    w = {ins, dat << (24 - n)};
    @(posedge clk) cs_n <= 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      sdi <= w[31 - i];
      repeat (5) @(posedge clk);
      @(negedge clk) begin
        rd = {rd[22:0], sdo_q};
        oe_seen = sdo_oe_n;
      end
      @(posedge clk) sclk <= 1'b1;
      repeat (5) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (6) @(posedge clk);
    cs_n <= 1'b1;
    tick(8);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      give_verdict;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    tick(4);
    chk(clk_factor_q, 5'h01, "factor");
    chk(vco_gain_high_q, 1'b0, "vco gain");
    chk(charge_pump_q, sysclk_pkg::pump_default, "pump");
    chk(ref_buffer_enable_q, 1'b1, "ref buffer");
    spi(8'h83, 24'h0, 24);
    chk(rd, sysclk_pkg::chan_function_reset, "chan reg");
    chk(oe_seen, 1'b0, "sdo enable on read");
    spi(8'h85, 24'h0, 24);
    chk(rd, 24'h0, "unmapped");
    chk(oe_seen, 1'b0, "sdo enable unmapped");
    chk(sdo_oe_n, 1'b1, "sdo release");
    $display("test reset done");
    foreach (mults[k]) begin
      spi(8'h01, {1'b0, mults[k], 18'h0}, 24);
      tick(lock_wait);
      inr = mults[k] >= 5'h04 && mults[k] <= 5'h14;
      chk(pll_enable_q, inr, "pll enable");
      chk(pll_powered_q, inr, "pll powered");
      chk(clk_factor_q, inr ? mults[k] : 5'h01, "factor");
    end
    spi(8'h81, 24'h0, 24);
    chk(rd, 24'h7c0000, "global reg");
    spi(8'h01, 24'hab0000, 24);
    chk({vco_gain_high_q, charge_pump_q}, 3'h7, "vco and pump");
    chk(oe_seen, 1'b1, "sdo idle on write");
    $display("test multiplier done");
    spi(8'h00, 24'h40, 8);
    for (int c = 0; c < 4; c++) begin
      spi(8'h03, {14'h0, c[1:0], 8'h0}, 24);
      chk(dac0_atten_q, atten_exp[c], "dac0 scale");
      chk(dac1_atten_q, 2'h0, "dac1 scale");
    end
    $display("test dac scale done");
    spi(8'h00, 24'hc0, 8);
    spi(8'h03, 24'h000340, 24);
    spi(8'h01, 24'h000080, 24);
    chk({dac0_pd_q, digital0_pd_q, dac1_pd_q, digital1_pd_q, clk_input_pd_q,
      fast_recovery_pd_q, full_pd_q}, 7'h2c, "digital pd");
    spi(8'h03, 24'h0003c0, 24);
    chk({dac0_pd_q, digital0_pd_q, dac1_pd_q, digital1_pd_q, clk_input_pd_q,
      fast_recovery_pd_q, full_pd_q}, 7'h7c, "soft pd");
    @(posedge clk) pd_req <= 1'b1;
    tick(8);
    chk({dac0_pd_q, digital0_pd_q, dac1_pd_q, digital1_pd_q, clk_input_pd_q,
      fast_recovery_pd_q, full_pd_q}, 7'h2a, "fast pd");
    spi(8'h01, 24'h500040, 24);
    chk({dac0_pd_q, digital0_pd_q, dac1_pd_q, digital1_pd_q, clk_input_pd_q,
      fast_recovery_pd_q, full_pd_q}, 7'h7d, "full pd");
    chk({pll_enable_q, pll_powered_q, xtal_osc_enable_q, ref_buffer_enable_q}, 4'h8,
      "full pd clocks");
    $display("test power-down done");
    @(posedge clk) begin
      pd_req <= 1'b0;
      xtal_req <= 1'b1;
    end
    tick(8);
    chk({pll_powered_q, xtal_osc_enable_q, ref_buffer_enable_q, full_pd_q}, 4'hc,
      "crystal mode");
    $display("test crystal done");
    give_verdict;
  end
endmodule
bind sysclk_and_powerdown_ctrl sysclk_monitor i_mon (.clk, .rstn, .clk_mode_sel,
  .external_powerdown_pin, .pll_enable_q, .pll_powered_q, .clk_factor_q, .vco_gain_high_q,
  .charge_pump_q, .xtal_osc_enable_q, .ref_buffer_enable_q, .clk_input_pd_q,
  .fast_recovery_pd_q, .full_pd_q, .dac0_pd_q, .digital0_pd_q, .dac1_pd_q, .digital1_pd_q);
`default_nettype wire
